// [logic/msc_top.v]
// MAC statistics counters and management controls behind an AXI4-Lite slave
//
// What this block does
// - Count good transmissions to group addresses other than broadcast.
// - Count good broadcast transmissions separately; other groups never touch it.
// - Count excessive deferral once per client transmission when the overrun flag is set.
// - Count good receptions to active non-broadcast groups, excluding every error or loss.
// - Count good broadcast receptions, excluding every error or internally lost frame.
// - Count length field in data range that differs from octets received.
// - Also count short length field while received octets exceed the minimum.
// - Count length fields above the maximum; type values count as good instead.
// - Count every reception ending too long.
// - A single fixed limit uses the tagged maximum, sparing valid tagged frames.
// - Oversize counter is nonresettable and keeps up with its peak rate.
// - Writing true sets both enables, idles the MAC, resets signaling; reads both.
// - Writing false clears both enables, ending all transfers, MAC disabled.
// - Transmit enable reads back; set allows, clear blocks further frames.
// - Multicast receive enable reads back; clear blocks, set restores group reception.
// - Thirty-two collision counters; success after n attempts bumps entry n-1.
// - Histogram and deferral counter are undefined in full duplex.
// - Report half duplex and full duplex capability as two indications.
// - Duplex setting reads half, full or unknown; writes ignored when fixed.
// - Initialize action runs MAC initialization and resets physical signaling.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`include "msc_regs.vh"

module msc_top #(
  parameter HALF_ABLE         = 1,
  parameter FULL_ABLE         = 1,
  parameter DUPLEX_CHANGEABLE = 1
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        tx_status_valid,
  input  wire        tx_good_status,
  input  wire        tx_dest_group,
  input  wire        tx_dest_bcast,
  input  wire        defer_overrun_flag,
  input  wire [5:0]  tx_attempts,
  input  wire        rx_status_valid,
  input  wire        rx_good_status,
  input  wire        rx_lost_internal,
  input  wire        rx_dest_group,
  input  wire        rx_dest_bcast,
  input  wire        rx_group_active,
  input  wire        oversize_status,
  input  wire [15:0] rx_frame_len,
  input  wire [15:0] rx_len_field,
  input  wire [15:0] rx_data_octets,
  output reg         rx_allow,
  output reg         tx_allow,
  output reg         group_rx_allow,
  output reg  [47:0] station_addr,
  output reg  [1:0]  duplex_setting,
  output reg         mac_init_pulse,
  output reg         phys_signaling_sublayer_reset
);

  localparam [15:0] OVERSIZE_LIMIT = `MSC_PLAIN_FRAME_LIMIT + `MSC_TAG_EXTRA_LEN;

  reg  [31:0] count [0:`MSC_COUNT_SLOTS-1];
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;
  reg         rd_busy;
  reg         rd_phase;
  reg  [7:0]  rd_addr;
  reg  [31:0] next_rdata;
  reg         next_rerr;
  reg  [1:0]  next_duplex;
  reg         next_aw_held;
  reg         next_w_held;
  reg         next_rd_busy;
  wire [31:0] hist_rd_data;
  wire [1:0]  duplex_ability;
  wire        aw_take;
  wire        w_take;
  wire        b_take;
  wire        ar_take;
  wire        r_take;
  wire        do_write;
  wire        wr_mapped;
  wire [47:0] merged_lo;
  wire [31:0] merged_hi_word;
  wire        too_long;
  wire        rx_clean;
  wire        tx_good;
  wire        hist_inc;
  wire [4:0]  hist_idx;
  wire        len_is_type;
  wire        len_mismatch;
  wire        len_overrange;
  wire [7:0]  count_hit;
  integer     k;

  // Merge write data into an old word under byte strobes
  function [31:0] msc_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      b;
    begin
      msc_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          msc_merge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  // Decode whether an address falls on a defined word
  function msc_mapped;
    input [7:0] addr;
    begin
      msc_mapped = (addr[1:0] == 2'b00) &&
                   ((addr <= `MSC_DUPLEX_ABILITY) ||
                    ((addr >= `MSC_COUNT_BASE) && (addr < `MSC_COUNT_BASE + 8'h20)) ||
                    (addr >= `MSC_HIST_BASE));
    end
  endfunction

  // Wrapping counter step
  function [31:0] msc_bump;
    input [31:0] value;
    begin
      msc_bump = value + 32'h00000001;
    end
  endfunction

  // Capability indications, fixed by parameters
  assign duplex_ability[`MSC_BIT_HALF_ABLE] = (HALF_ABLE != 0);
  assign duplex_ability[`MSC_BIT_FULL_ABLE] = (FULL_ABLE != 0);

  // Bus handshakes
  assign aw_take  = s_axi_awvalid & s_axi_awready;
  assign w_take   = s_axi_wvalid & s_axi_wready;
  assign b_take   = s_axi_bvalid & s_axi_bready;
  assign ar_take  = s_axi_arvalid & s_axi_arready;
  assign r_take   = s_axi_rvalid & s_axi_rready;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_mapped = msc_mapped(wr_addr);

  // Station address with one half replaced
  assign merged_lo = {station_addr[47:32], msc_merge(station_addr[31:0], wr_data, wr_strb)};
  assign merged_hi_word = msc_merge({16'h0000, station_addr[47:32]}, wr_data, wr_strb);

  // Frame classification from the status reports
  assign too_long  = oversize_status | (rx_frame_len > OVERSIZE_LIMIT);
  assign rx_clean  = rx_status_valid & rx_good_status & ~too_long & ~rx_lost_internal;
  assign tx_good   = tx_status_valid & tx_good_status;
  assign len_is_type = rx_len_field >= `MSC_TYPE_FIELD_MIN;
  assign len_mismatch = rx_status_valid & ~rx_lost_internal &
                        (((rx_len_field >= `MSC_MIN_CLIENT_DATA) &&
                          (rx_len_field <= `MSC_MAX_CLIENT_DATA) &&
                          (rx_len_field != rx_data_octets)) ||
                         ((rx_len_field < `MSC_MIN_CLIENT_DATA) &&
                          (rx_data_octets > `MSC_MIN_CLIENT_DATA)));
  assign len_overrange = rx_status_valid & ~rx_lost_internal &
                         (rx_len_field > `MSC_MAX_CLIENT_DATA) & ~len_is_type;

  // Which counter each report touches
  assign count_hit[`MSC_CNT_GROUP_TX]      = tx_good & tx_dest_group & ~tx_dest_bcast;
  assign count_hit[`MSC_CNT_BCAST_TX]      = tx_good & tx_dest_bcast;
  assign count_hit[`MSC_CNT_LONG_WAIT]     = tx_status_valid & defer_overrun_flag;
  assign count_hit[`MSC_CNT_GROUP_RX]      = rx_clean & rx_dest_group & ~rx_dest_bcast &
                                             rx_group_active & group_rx_allow;
  assign count_hit[`MSC_CNT_BCAST_RX]      = rx_clean & rx_dest_bcast;
  assign count_hit[`MSC_CNT_LEN_MISMATCH]  = len_mismatch;
  assign count_hit[`MSC_CNT_LEN_OVERRANGE] = len_overrange;
  assign count_hit[`MSC_CNT_OVERSIZE]      = rx_status_valid & too_long;

  // Histogram entry n-1 for success after n attempts
  assign hist_inc = tx_good & (tx_attempts >= 6'd1) & (tx_attempts <= 6'd32);
  assign hist_idx = tx_attempts[4:0] - 5'd1;

  msc_hist_mem #(
    .DEPTH (`MSC_HIST_DEPTH),
    .AW    (5)
  ) u_hist (
    .clock   (clock),
    .reset_n (reset_n),
    .inc_en  (hist_inc),
    .inc_idx (hist_idx),
    .rd_en   (ar_take),
    .rd_idx  (s_axi_araddr[6:2]),
    .rd_data (hist_rd_data)
  );

  // Statistics counters, cleared only by hardware reset
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (k = 0; k < `MSC_COUNT_SLOTS; k = k + 1) begin
        count[k] <= 32'h00000000;
      end
    end else begin
      for (k = 0; k < `MSC_COUNT_SLOTS; k = k + 1) begin
        if (count_hit[k]) begin
          count[k] <= msc_bump(count[k]);
        end
      end
    end
  end

  // Duplex write filter: only supported modes on a changeable device
  always @* begin
    next_duplex = duplex_setting;
    if ((DUPLEX_CHANGEABLE != 0) && (HALF_ABLE != 0) && (FULL_ABLE != 0)) begin
      if ((wr_data[1:0] == `MSC_DUPLEX_HALF) || (wr_data[1:0] == `MSC_DUPLEX_FULL)) begin
        next_duplex = wr_data[1:0];
      end
    end
  end

  // Next state of the bus holding flags
  always @* begin
    next_aw_held = (aw_held | aw_take) & ~b_take;
    next_w_held  = (w_held | w_take) & ~b_take;
    next_rd_busy = (rd_busy | ar_take) & ~r_take;
  end

  // Write channels, response and control registers
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `MSC_RESP_OKAY;
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      wr_addr        <= 8'h00;
      wr_data        <= 32'h00000000;
      wr_strb        <= 4'h0;
      rx_allow       <= `MSC_RST_ALLOW;
      tx_allow       <= `MSC_RST_ALLOW;
      group_rx_allow <= `MSC_RST_GROUP_RX_ALLOW;
      station_addr   <= `MSC_RST_STATION_ADDR;
      duplex_setting <= `MSC_RST_DUPLEX;
      mac_init_pulse <= 1'b0;
      phys_signaling_sublayer_reset <= 1'b0;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready  <= ~next_w_held;
      mac_init_pulse <= 1'b0;
      phys_signaling_sublayer_reset <= 1'b0;
      if (aw_take) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (b_take) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `MSC_RESP_OKAY : `MSC_RESP_SLVERR;
        if (wr_strb[0]) begin
          case (wr_addr)
            `MSC_MAC_RUN_CTL: begin
              rx_allow <= wr_data[`MSC_BIT_ENABLE];
              tx_allow <= wr_data[`MSC_BIT_ENABLE];
              mac_init_pulse <= wr_data[`MSC_BIT_ENABLE];
              phys_signaling_sublayer_reset <= wr_data[`MSC_BIT_ENABLE];
            end
            `MSC_TX_ALLOW_CTL: begin
              tx_allow <= wr_data[`MSC_BIT_ENABLE];
            end
            `MSC_GROUP_RX_ALLOW_CTL: begin
              group_rx_allow <= wr_data[`MSC_BIT_ENABLE];
            end
            `MSC_INIT_ACTION: begin
              mac_init_pulse <= wr_data[`MSC_BIT_ENABLE];
              phys_signaling_sublayer_reset <= wr_data[`MSC_BIT_ENABLE];
            end
            `MSC_DUPLEX_SETTING: begin
              duplex_setting <= next_duplex;
            end
            default: begin
            end
          endcase
        end
        if (wr_addr == `MSC_STATION_ADDR_LO) begin
          station_addr <= merged_lo;
        end
        if (wr_addr == `MSC_STATION_ADDR_HI) begin
          station_addr <= {merged_hi_word[15:0], station_addr[31:0]};
        end
      end
    end
  end

  // Read data selection, valid one cycle after the address is taken
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    if (!msc_mapped(rd_addr)) begin
      next_rerr = 1'b1;
    end else if (rd_addr >= `MSC_HIST_BASE) begin
      next_rdata = hist_rd_data;
    end else if (rd_addr >= `MSC_COUNT_BASE) begin
      next_rdata = count[rd_addr[4:2]];
    end else begin
      case (rd_addr)
        `MSC_MAC_RUN_CTL:        next_rdata = {31'h0, rx_allow & tx_allow};
        `MSC_TX_ALLOW_CTL:       next_rdata = {31'h0, tx_allow};
        `MSC_GROUP_RX_ALLOW_CTL: next_rdata = {31'h0, group_rx_allow};
        `MSC_STATION_ADDR_LO:    next_rdata = station_addr[31:0];
        `MSC_STATION_ADDR_HI:    next_rdata = {16'h0000, station_addr[47:32]};
        `MSC_DUPLEX_SETTING:     next_rdata = {30'h0, duplex_setting};
        `MSC_DUPLEX_ABILITY:     next_rdata = {30'h0, duplex_ability};
        default:                 next_rdata = 32'h00000000;
      endcase
    end
  end

  // Read channels
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MSC_RESP_OKAY;
      rd_busy       <= 1'b0;
      rd_phase      <= 1'b0;
      rd_addr       <= 8'h00;
    end else begin
      rd_busy       <= next_rd_busy;
      s_axi_arready <= ~next_rd_busy;
      rd_phase      <= ar_take;
      if (ar_take) begin
        rd_addr <= s_axi_araddr;
      end
      if (r_take) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_phase) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rerr ? `MSC_RESP_SLVERR : `MSC_RESP_OKAY;
      end
    end
  end

endmodule

// [logic/msc_regs.vh]
// Register offsets, field positions and reset values of the MAC statistics block
`ifndef MSC_REGS_VH
`define MSC_REGS_VH

// Control and setting registers
`define MSC_MAC_RUN_CTL        8'h00
`define MSC_TX_ALLOW_CTL       8'h04
`define MSC_GROUP_RX_ALLOW_CTL 8'h08
`define MSC_INIT_ACTION        8'h0c
`define MSC_STATION_ADDR_LO    8'h10
`define MSC_STATION_ADDR_HI    8'h14
`define MSC_DUPLEX_SETTING     8'h18
`define MSC_DUPLEX_ABILITY     8'h1c

// Statistics counters, one word each from this base
`define MSC_COUNT_BASE         8'h40
`define MSC_COUNT_SLOTS        8
`define MSC_CNT_GROUP_TX       3'd0
`define MSC_CNT_BCAST_TX       3'd1
`define MSC_CNT_LONG_WAIT      3'd2
`define MSC_CNT_GROUP_RX       3'd3
`define MSC_CNT_BCAST_RX       3'd4
`define MSC_CNT_LEN_MISMATCH   3'd5
`define MSC_CNT_LEN_OVERRANGE  3'd6
`define MSC_CNT_OVERSIZE       3'd7

// Collision histogram window, 32 words
`define MSC_HIST_BASE          8'h80
`define MSC_HIST_DEPTH         32

// Field positions
`define MSC_BIT_ENABLE         0
`define MSC_BIT_HALF_ABLE      0
`define MSC_BIT_FULL_ABLE      1

// Duplex setting encodings
`define MSC_DUPLEX_UNKNOWN     2'd0
`define MSC_DUPLEX_HALF        2'd1
`define MSC_DUPLEX_FULL        2'd2

// Reset values
`define MSC_RST_DUPLEX         2'd1
`define MSC_RST_STATION_ADDR   48'h020000000001
`define MSC_RST_ALLOW          1'b0
`define MSC_RST_GROUP_RX_ALLOW 1'b1

// Frame size figures in octets
`define MSC_MIN_CLIENT_DATA    16'd46
`define MSC_MAX_CLIENT_DATA    16'd1500
`define MSC_TYPE_FIELD_MIN     16'h0600
`define MSC_PLAIN_FRAME_LIMIT  16'd1518
`define MSC_TAG_EXTRA_LEN      16'd4

// AXI responses
`define MSC_RESP_OKAY          2'b00
`define MSC_RESP_SLVERR        2'b10

`endif

// [logic/msc_hist_mem.v]
// Collision histogram memory with in-place increment and registered read
module msc_hist_mem #(
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire          clock,
  input  wire          reset_n,
  input  wire          inc_en,
  input  wire [AW-1:0] inc_idx,
  input  wire          rd_en,
  input  wire [AW-1:0] rd_idx,
  output reg  [31:0]   rd_data
);

  reg [31:0] mem [0:DEPTH-1];
  integer    i;

  // Increment one entry, wrapping at the top
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= 32'h00000000;
      end
    end else if (inc_en) begin
      mem[inc_idx] <= mem[inc_idx] + 32'h00000001;
    end
  end

  // Registered read port
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 32'h00000000;
    end else if (rd_en) begin
      rd_data <= mem[rd_idx];
    end
  end

endmodule

// [tb/msc_top_chk.sv]
// Port-level checks for the MAC statistics block
module msc_top_chk (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx_allow,
  input wire logic        tx_allow,
  input wire logic [1:0]  duplex_setting,
  input wire logic        mac_init_pulse,
  input wire logic        phys_signaling_sublayer_reset
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Answers hold until taken
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp moved early");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("rdata moved early");
  // Bounded answer latency
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("no bresp");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
    else $error("no rdata");
  // One transfer per direction
  a_aw_busy:
    assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("aw reopened early");
  a_ar_busy:
    assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready [*2])
    else $error("ar reopened early");
  // Init pulses paired
  a_init_pair:
    assert property (mac_init_pulse |-> phys_signaling_sublayer_reset ##1 !mac_init_pulse)
    else $error("init pulse bad");
  // Receive enable changes only to match transmit enable, duplex setting stays legal
  a_enable_pair:
    assert property ($changed(rx_allow) |-> rx_allow == tx_allow)
    else $error("enables split");
  a_enable_init:
    assert property ($rose(rx_allow) |-> ##[0:1] mac_init_pulse)
    else $error("enable without init");
  a_duplex_legal:
    assert property (duplex_setting == 2'd1 || duplex_setting == 2'd2)
    else $error("duplex illegal");

  // Main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_init: cover property (mac_init_pulse);
  c_enable: cover property ($rose(rx_allow));
endmodule

bind msc_top msc_top_chk u_chk (.*);

// [tb/msc_status_src.sv]
// Model of the MAC transmit and receive engines reporting frame status
module msc_status_src (
  input  wire logic        clock,
  output logic        tx_status_valid,
  output logic        tx_good_status,
  output logic        tx_dest_group,
  output logic        tx_dest_bcast,
  output logic        defer_overrun_flag,
  output logic [5:0]  tx_attempts,
  output logic        rx_status_valid,
  output logic        rx_good_status,
  output logic        rx_lost_internal,
  output logic        rx_dest_group,
  output logic        rx_dest_bcast,
  output logic        rx_group_active,
  output logic        oversize_status,
  output logic [15:0] rx_frame_len,
  output logic [15:0] rx_len_field,
  output logic [15:0] rx_data_octets
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet link at time zero
  initial begin
    {tx_status_valid, tx_good_status, tx_dest_group, tx_dest_bcast, defer_overrun_flag, tx_attempts} = '0;
    {rx_status_valid, rx_good_status, rx_lost_internal, rx_dest_group, rx_dest_bcast} = '0;
    {rx_group_active, oversize_status, rx_frame_len, rx_len_field, rx_data_octets} = '0;
  end

  // One report per transmission, n of them back to back
  task automatic send_tx(input logic g, gr, bc, df, input logic [5:0] at, input int n);
    repeat (n) begin
      @(posedge clock);
      tx_status_valid <= 1'b1;
      {tx_good_status, tx_dest_group, tx_dest_bcast, defer_overrun_flag, tx_attempts} <= {g, gr, bc, df, at};
    end
    @(posedge clock);
    tx_status_valid <= 1'b0;
    // Released qualifiers show the inverse, not a stale value
    {tx_good_status, tx_dest_group, tx_dest_bcast, defer_overrun_flag, tx_attempts} <= ~{g, gr, bc, df, at};
  endtask

  // One reception report
  task automatic send_rx(input logic g, ls, gr, bc, ac, ov, input logic [15:0] fl, lf, oc);
    @(posedge clock);
    rx_status_valid <= 1'b1;
    {rx_good_status, rx_lost_internal, rx_dest_group, rx_dest_bcast, rx_group_active} <= {g, ls, gr, bc, ac};
    {oversize_status, rx_frame_len, rx_len_field, rx_data_octets} <= {ov, fl, lf, oc};
    @(posedge clock);
    rx_status_valid <= 1'b0;
    {rx_good_status, rx_lost_internal, rx_dest_group, rx_dest_bcast, rx_group_active} <= ~{g, ls, gr, bc, ac};
    {oversize_status, rx_frame_len, rx_len_field, rx_data_octets} <= ~{ov, fl, lf, oc};
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the MAC statistics and control block
`include "msc_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic tx, g, gr, bc, fl, ac, ov;
    logic [5:0]  at;
    logic [15:0] flen, lf, oc;
    logic [7:0]  inc;
  } msc_row_t;

  logic        clock = 1'b0, reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp, duplex_setting;
  wire [31:0]  s_axi_rdata;
  wire         tx_status_valid, tx_good_status, tx_dest_group, tx_dest_bcast, defer_overrun_flag;
  wire [5:0]   tx_attempts;
  wire         rx_status_valid, rx_good_status, rx_lost_internal, rx_dest_group, rx_dest_bcast;
  wire         rx_group_active, oversize_status;
  wire [15:0]  rx_frame_len, rx_len_field, rx_data_octets;
  wire         rx_allow, tx_allow, group_rx_allow, mac_init_pulse, phys_signaling_sublayer_reset;
  wire [47:0]  station_addr;
  int          num_errors = 0, check_count = 0, init_seen = 0, n0;
  logic [31:0] exp_cnt [8];
  logic [31:0] exp_hist [32];
  msc_row_t    r;
  // Reports and counters bumped, bit k = slot k
  msc_row_t    rows [18] = '{
    '{1, 1, 1, 0, 0, 0, 0, 1, 64, 0, 0, 8'h01}, '{1, 1, 1, 1, 0, 0, 0, 32, 64, 0, 0, 8'h02},
    '{1, 0, 1, 0, 1, 0, 0, 5, 64, 0, 0, 8'h04}, '{1, 1, 0, 0, 1, 0, 0, 2, 64, 0, 0, 8'h04},
    '{0, 1, 1, 0, 0, 1, 0, 0, 100, 16'h800, 86, 8'h08}, '{0, 1, 1, 1, 0, 1, 0, 0, 100, 16'h800, 86, 8'h10},
    '{0, 0, 1, 0, 0, 1, 0, 0, 100, 16'h800, 86, 0}, '{0, 1, 1, 0, 1, 1, 0, 0, 100, 16'h800, 86, 0},
    '{0, 1, 1, 0, 0, 0, 0, 0, 100, 16'h800, 86, 0}, '{0, 0, 0, 0, 0, 0, 0, 0, 100, 46, 50, 8'h20},
    '{0, 0, 0, 0, 0, 0, 0, 0, 1518, 1500, 1500, 0}, '{0, 0, 0, 0, 0, 0, 0, 0, 100, 20, 47, 8'h20},
    '{0, 0, 0, 0, 0, 0, 0, 0, 100, 20, 46, 0}, '{0, 0, 0, 0, 0, 0, 0, 0, 100, 1501, 100, 8'h40},
    '{0, 0, 0, 0, 0, 0, 0, 0, 100, 16'h600, 100, 0}, '{0, 0, 0, 0, 0, 0, 1, 0, 100, 16'h800, 86, 8'h80},
    '{0, 1, 0, 0, 0, 0, 0, 0, 1522, 16'h800, 1504, 0}, '{0, 0, 0, 0, 0, 0, 0, 0, 1523, 16'h800, 1505, 8'h80}};

  msc_top u_dut (.*);
  msc_status_src u_src (.*);

  always #20 clock = ~clock;
  // Count initialization pulses
  always @(posedge clock) if (mac_init_pulse & phys_signaling_sublayer_reset) init_seen <= init_seen + 1;

  task automatic conclude;
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write with address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] rexp);
    int n;
    logic ap, wp;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    {ap, wp, n} = {2'b11, 32'd0};
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) ap = 1'b0;
      if (s_axi_wready) wp = 1'b0;
      s_axi_awvalid <= ap;
      s_axi_wvalid <= wp;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(rexp));
    num_errors += (n >= 40);
    if (n >= 40) conclude;
  endtask
  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    int n;
    logic ap;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    {ap, n} = {1'b1, 32'd0};
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) ap = 1'b0;
      s_axi_arvalid <= ap;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(rexp));
    num_errors += (n >= 40);
    if (n >= 40) conclude;
  endtask
  task automatic chk_counts;
    for (int j = 0; j < 8; j++) rd(`MSC_COUNT_BASE + 8'(4 * j), exp_cnt[j], 2'b00);
  endtask

  initial begin
    foreach (exp_cnt[j]) exp_cnt[j] = 32'h0;
    foreach (exp_hist[j]) exp_hist[j] = 32'h0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    // Reset state
    rd(`MSC_MAC_RUN_CTL, 32'h0, 2'b00);
    rd(`MSC_GROUP_RX_ALLOW_CTL, 32'h1, 2'b00);
    rd(`MSC_STATION_ADDR_LO, 32'h1, 2'b00);
    rd(`MSC_STATION_ADDR_HI, 32'h200, 2'b00);
    rd(`MSC_DUPLEX_SETTING, 32'h1, 2'b00);
    rd(`MSC_DUPLEX_ABILITY, 32'h3, 2'b00);
    chk_counts;
    // Table of status reports
    for (int i = 0; i < 18; i++) begin
      r = rows[i];
      if (r.tx) u_src.send_tx(r.g, r.gr, r.bc, r.fl, r.at, 1);
      else u_src.send_rx(r.g, r.fl, r.gr, r.bc, r.ac, r.ov, r.flen, r.lf, r.oc);
      for (int k = 0; k < 8; k++) if (r.inc[k]) exp_cnt[k]++;
      if (r.tx && r.g) exp_hist[r.at - 6'd1]++;
      chk_counts;
    end
    // Back-to-back reports every cycle
    u_src.send_tx(1'b1, 1'b1, 1'b0, 1'b0, 6'd1, 4);
    exp_cnt[0] += 4;
    exp_hist[0] += 4;
    chk_counts;
    for (int i = 0; i < 32; i++) rd(`MSC_HIST_BASE + 8'(4 * i), exp_hist[i], 2'b00);
    // Run control, transmit control, initialize action
    n0 = init_seen;
    wr(`MSC_MAC_RUN_CTL, 32'h1, 2'b00);
    rd(`MSC_MAC_RUN_CTL, 32'h1, 2'b00);
    chk({29'h0, rx_allow, tx_allow, group_rx_allow}, 32'h7);
    chk(init_seen, n0 + 1);
    wr(`MSC_TX_ALLOW_CTL, 32'h0, 2'b00);
    rd(`MSC_TX_ALLOW_CTL, 32'h0, 2'b00);
    rd(`MSC_MAC_RUN_CTL, 32'h0, 2'b00);
    chk({30'h0, rx_allow, tx_allow}, 32'h2);
    wr(`MSC_MAC_RUN_CTL, 32'h0, 2'b00);
    rd(`MSC_INIT_ACTION, 32'h0, 2'b00);
    chk({30'h0, rx_allow, tx_allow}, 32'h0);
    wr(`MSC_INIT_ACTION, 32'h1, 2'b00);
    rd(`MSC_INIT_ACTION, 32'h0, 2'b00);
    chk(init_seen, n0 + 2);
    // Group reception blocked, then restored
    wr(`MSC_GROUP_RX_ALLOW_CTL, 32'h0, 2'b00);
    u_src.send_rx(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'd100, 16'h800, 16'd86);
    rd(`MSC_GROUP_RX_ALLOW_CTL, 32'h0, 2'b00);
    rd(`MSC_COUNT_BASE + 8'h0c, exp_cnt[3], 2'b00);
    wr(`MSC_GROUP_RX_ALLOW_CTL, 32'h1, 2'b00);
    u_src.send_rx(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'd100, 16'h800, 16'd86);
    exp_cnt[3]++;
    rd(`MSC_COUNT_BASE + 8'h0c, exp_cnt[3], 2'b00);
    // Station address: group bit clear, not null
    wr(`MSC_STATION_ADDR_LO, 32'h89abcdef, 2'b00);
    wr(`MSC_STATION_ADDR_HI, 32'h00000a02, 2'b00);
    rd(`MSC_STATION_ADDR_HI, 32'h00000a02, 2'b00);
    chk(station_addr[47:16], 32'h0a0289ab);
    // Duplex: legal writes switch, illegal code ignored
    wr(`MSC_DUPLEX_SETTING, 32'h2, 2'b00);
    wr(`MSC_DUPLEX_SETTING, 32'h3, 2'b00);
    rd(`MSC_DUPLEX_SETTING, 32'h2, 2'b00);
    wr(`MSC_DUPLEX_SETTING, 32'h1, 2'b00);
    rd(`MSC_DUPLEX_SETTING, 32'h1, 2'b00);
    // Refusals and counters surviving writes and enables
    rd(8'h20, 32'h0, `MSC_RESP_SLVERR);
    rd(8'h02, 32'h0, `MSC_RESP_SLVERR);
    wr(8'h60, 32'h1, `MSC_RESP_SLVERR);
    wr(`MSC_COUNT_BASE, 32'hffffffff, `MSC_RESP_OKAY);
    chk_counts;
    conclude;
  end
endmodule
